// ===== logic/cpfs_consts.svh
// Summary of operation
// RL1 - Code 0100: pin A picks 100/500 mA, pin B high picks 1500 mA, pin C high disables the regulator.
// RL2 - Code 0101: pins A and B set the current limit as in 0100 and pin C high enables charging.
// RL3 - Code 0110: pin B high disables recharge, pin C gates charging; code 0111: A charging, B disable, C recharge.
// RL4 - Codes 1000 to 1111 drive pin C as interrupt output; code 1001: B gates charging, A picks 100/500 mA.
// RL5 - Code 1100: pin B high halves fast charge current; 1010, 1011, 1101 give B disable, recharge, regulator.
// RL6 - Code 1110: pin A high picks 1500 mA and pin B gates charging; code 1111: pin A drives circuit disable.
// RL7 - Code 0000: pin A picks 100/500 mA, pin B drives circuit disable, pin C high enables charging.
// RL8 - Polarity bit 0 keeps pin A active high, 1 makes it active low.
// RL9 - Unlisted codes leave every pin without effect and the interrupt output inactive.
//
// constants for the configurable pin function selector
// assumes one 100 MHz clock and a 4-bit AXI4-Lite address
`ifndef CPFS_CONSTS_SVH
`define CPFS_CONSTS_SVH

`define CPFS_OPT_0      4'h0
`define CPFS_OPT_2      4'h2
`define CPFS_OPT_3      4'h3
`define CPFS_OPT_4      4'h4
`define CPFS_OPT_5      4'h5
`define CPFS_OPT_6      4'h6
`define CPFS_OPT_7      4'h7
`define CPFS_OPT_8      4'h8
`define CPFS_OPT_9      4'h9
`define CPFS_OPT_A      4'hA
`define CPFS_OPT_B      4'hB
`define CPFS_OPT_C      4'hC
`define CPFS_OPT_D      4'hD
`define CPFS_OPT_E      4'hE
`define CPFS_OPT_F      4'hF
`define CPFS_OPT_BAD    4'h1
`define CPFS_IRQ_BIT    3

`define CPFS_ADDR_CFG   4'h0
`define CPFS_ADDR_STATE 4'h4
`define CPFS_ADDR_ISTAT 4'h8
`define CPFS_ADDR_IMASK 4'hC
`define CPFS_CFG_RST    5'h00
`define CPFS_CODE_MSB   3
`define CPFS_POL_BIT    4
`define CPFS_NEV        6
`define CPFS_IMASK_RST  6'h00
`define CPFS_RESP_OKAY  2'h0
`define CPFS_RESP_SLV   2'h2

`endif

// ===== logic/cpfs_pkg.sv
// types and pin function decode for the selector
// assumes cpfs_consts.svh is on the include path
`include "cpfs_consts.svh"
package cpfs_pkg;
    typedef enum logic [1:0] {
        CPFS_LIM_NONE = 2'h0,
        CPFS_LIM_100  = 2'h1,
        CPFS_LIM_500  = 2'h2,
        CPFS_LIM_1500 = 2'h3
    } cpfs_limit_t;

    typedef struct packed {
        cpfs_limit_t lim;
        logic        chgEn;
        logic        chgOwn;
        logic        rch;
        logic        regOff;
        logic        half;
        logic        cd;
        logic        irqPin;
    } cpfs_func_t;

    // map option code and pin levels onto charger functions
    function automatic cpfs_func_t cpfs_decode(input logic [3:0] code, input logic a, input logic b,
                                               input logic c);
        cpfs_limit_t limA;
        cpfs_limit_t limB;
        cpfs_func_t  f;
        limA = a ? CPFS_LIM_500 : CPFS_LIM_100;
        limB = b ? CPFS_LIM_1500 : limA;
        f = '0;
        f.irqPin = code[`CPFS_IRQ_BIT]; // RL4
        case (code)
            `CPFS_OPT_0: begin f.lim = limA; f.cd = b; f.chgEn = c; f.chgOwn = 1'b1; end // RL7
            `CPFS_OPT_2: begin f.lim = limB; f.cd = c; end
            `CPFS_OPT_3: begin f.lim = limB; f.half = c; end
            `CPFS_OPT_4: begin f.lim = limB; f.regOff = c; end // RL1
            `CPFS_OPT_5: begin f.lim = limB; f.chgEn = c; f.chgOwn = 1'b1; end // RL2
            `CPFS_OPT_6: begin f.lim = limA; f.rch = b; f.chgEn = c; f.chgOwn = 1'b1; end // RL3
            `CPFS_OPT_7: begin f.chgEn = a; f.chgOwn = 1'b1; f.cd = b; f.rch = c; end // RL3
            `CPFS_OPT_8: begin f.lim = limB; end
            `CPFS_OPT_9: begin f.lim = limA; f.chgEn = b; f.chgOwn = 1'b1; end // RL4
            `CPFS_OPT_A: begin f.lim = limA; f.cd = b; end // RL5
            `CPFS_OPT_B: begin f.lim = limA; f.rch = b; end // RL5
            `CPFS_OPT_C: begin f.lim = limA; f.half = b; end // RL5
            `CPFS_OPT_D: begin f.lim = limA; f.regOff = b; end // RL5
            `CPFS_OPT_E: begin f.lim = a ? CPFS_LIM_1500 : CPFS_LIM_NONE; f.chgEn = b; f.chgOwn = 1'b1; end // RL6
            `CPFS_OPT_F: begin f.cd = a; f.chgEn = b; f.chgOwn = 1'b1; end // RL6
            default: f = '0; // RL9
        endcase
        return f;
    endfunction : cpfs_decode
endpackage : cpfs_pkg

// ===== logic/cpfs_axil_port.sv
// AXI4-Lite slave front end for the selector registers
// assumes the parent answers rdData/rdOk and wrOk combinationally
`timescale 1ns/1ps
`include "cpfs_consts.svh"
module cpfs_axil_port (
    input  wire logic        clk,     // system clock
    input  wire logic        srst,    // sync reset, high
    input  wire logic [3:0]  awaddr,  // write address
    input  wire logic        awvalid, // write address valid
    output logic             awready, // write address ready
    input  wire logic [31:0] wdata,   // write data
    input  wire logic [3:0]  wstrb,   // write strobes
    input  wire logic        wvalid,  // write data valid
    output logic             wready,  // write data ready
    output logic [1:0]       bresp,   // write response
    output logic             bvalid,  // write response valid
    input  wire logic        bready,  // write response ready
    input  wire logic [3:0]  araddr,  // read address
    input  wire logic        arvalid, // read address valid
    output logic             arready, // read address ready
    output logic [31:0]      rdata,   // read data
    output logic [1:0]       rresp,   // read response
    output logic             rvalid,  // read data valid
    input  wire logic        rready,  // read data ready
    output logic             wrEn,    // register write pulse
    output logic [3:0]       wrAddr,  // register write address
    output logic [31:0]      wrData,  // register write data
    output logic [3:0]       wrStrb,  // register write strobes
    input  wire logic        wrOk,    // write address mapped
    output logic [3:0]       rdAddr,  // register read address
    input  wire logic [31:0] rdData,  // register read data
    input  wire logic        rdOk     // read address mapped
);
    logic awHeld;
    logic wHeld;

    // channel readiness and the write pulse once both halves are in
    assign awready = !awHeld && !bvalid;
    assign wready  = !wHeld && !bvalid;
    assign arready = !rvalid;
    assign wrEn    = awHeld && wHeld && !bvalid;
    assign rdAddr  = araddr;

    // write path: take address and data in either order
    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            wrAddr <= 4'h0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
            bvalid <= 1'b0;
            bresp  <= `CPFS_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld  <= 1'b1;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (wrEn) begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wrOk ? `CPFS_RESP_OKAY : `CPFS_RESP_SLV;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read path: data captured on the address handshake
    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `CPFS_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdData;
            rresp  <= rdOk ? `CPFS_RESP_OKAY : `CPFS_RESP_SLV;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : cpfs_axil_port

// ===== logic/cpfs_pin_select.sv
// configurable pin function selector with register bank and interrupt
// assumes pins are asynchronous to clk; registers reached over AXI4-Lite
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cpfs_consts.svh"
module cpfs_pin_select (
    input  wire logic        clk,                   // 100 MHz clock
    input  wire logic        srst,                  // sync reset, high
    input  wire logic [3:0]  awaddr,                // write address
    input  wire logic        awvalid,               // write address valid
    output logic             awready,               // write address ready
    input  wire logic [31:0] wdata,                 // write data
    input  wire logic [3:0]  wstrb,                 // write strobes
    input  wire logic        wvalid,                // write data valid
    output logic             wready,                // write data ready
    output logic [1:0]       bresp,                 // write response
    output logic             bvalid,                // write response valid
    input  wire logic        bready,                // write response ready
    input  wire logic [3:0]  araddr,                // read address
    input  wire logic        arvalid,               // read address valid
    output logic             arready,               // read address ready
    output logic [31:0]      rdata,                 // read data
    output logic [1:0]       rresp,                 // read response
    output logic             rvalid,                // read data valid
    input  wire logic        rready,                // read data ready
    input  wire logic        configPinAIn,          // pin a level
    input  wire logic        configPinBIn,          // pin b level
    input  wire logic        configPinCIn,          // pin c level
    output logic             configPinCOut,         // pin c driven level
    output logic             configPinCOe,          // pin c drive enable
    output logic [1:0]       inputLimitSel,         // 0 none,1 100,2 500,3 1500 mA
    output logic             chargeEnable,          // charging enabled by pin
    output logic             chargeCtrlOwned,       // a pin gates charging
    output logic             rechargeDisable,       // recharge disabled
    output logic             regulatorDisable,      // linear regulator disabled
    output logic             fastChargeHalve,       // halve fast_charge_current_setting
    output logic             chargerCircuitDisable, // charger_circuit_disable
    output logic             irq                    // interrupt, high active level
);
    logic [2:0]           pinMeta;
    logic [2:0]           pinSync;
    logic [4:0]           cfg;
    logic [`CPFS_NEV-1:0] intStatus;
    logic [`CPFS_NEV-1:0] intMask;
    cpfs_pkg::cpfs_func_t funcQ;
    logic                 wrEn;
    logic [3:0]           wrAddr;
    logic [31:0]          wrData;
    logic [3:0]           wrStrb;
    logic [3:0]           rdAddr;

    // pin synchronisers, two flops each
    wire [2:0] pinRaw = {configPinCIn, configPinBIn, configPinAIn};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    pinMeta[g] <= 1'b0;
                    pinSync[g] <= 1'b0;
                end else begin
                    pinMeta[g] <= pinRaw[g];
                    pinSync[g] <= pinMeta[g];
                end
            end
        end
    endgenerate

    // option code, polarity and the decoded functions
    wire [3:0] optCode = cfg[`CPFS_CODE_MSB:0];
    wire       polLow  = cfg[`CPFS_POL_BIT];
    wire       aEff    = pinSync[0] ^ polLow; // RL8
    wire cpfs_pkg::cpfs_func_t next_func = cpfs_pkg::cpfs_decode(optCode, aEff, pinSync[1], pinSync[2]); // RL7 RL9

    // first cycle after reset only loads funcQ, so its reset value never reads as an event
    logic primed;
    always_ff @(posedge clk) begin
        if (srst) primed <= 1'b0;
        else primed <= 1'b1;
    end

    // a change of any function other than the pin c interrupt role is an event
    wire [`CPFS_NEV-1:0] evRaw = {
        next_func.lim != funcQ.lim,
        {next_func.chgEn, next_func.chgOwn} != {funcQ.chgEn, funcQ.chgOwn},
        next_func.rch != funcQ.rch,
        next_func.regOff != funcQ.regOff,
        next_func.half != funcQ.half,
        next_func.cd != funcQ.cd
    };
    wire [`CPFS_NEV-1:0] evVec = primed ? evRaw : '0;

    // register decode
    wire wrCfg   = wrEn && wrAddr == `CPFS_ADDR_CFG && wrStrb[0];
    wire wrIstat = wrEn && wrAddr == `CPFS_ADDR_ISTAT && wrStrb[0];
    wire wrImask = wrEn && wrAddr == `CPFS_ADDR_IMASK && wrStrb[0];
    wire wrOk    = wrAddr == `CPFS_ADDR_CFG || wrAddr == `CPFS_ADDR_STATE ||
                   wrAddr == `CPFS_ADDR_ISTAT || wrAddr == `CPFS_ADDR_IMASK;
    wire rdOk    = rdAddr == `CPFS_ADDR_CFG || rdAddr == `CPFS_ADDR_STATE ||
                   rdAddr == `CPFS_ADDR_ISTAT || rdAddr == `CPFS_ADDR_IMASK;
    wire [`CPFS_NEV-1:0] clrMask = wrIstat ? wrData[`CPFS_NEV-1:0] : '0;
    wire [`CPFS_NEV-1:0] next_intStatus = (intStatus & ~clrMask) | evVec;
    wire [31:0] stateWord = {21'h0, pinSync, funcQ.cd, funcQ.half, funcQ.regOff, funcQ.rch,
                             funcQ.chgOwn, funcQ.chgEn, funcQ.lim};
    wire [31:0] rdData = rdAddr == `CPFS_ADDR_CFG   ? {27'h0, cfg} :
                         rdAddr == `CPFS_ADDR_STATE ? stateWord :
                         rdAddr == `CPFS_ADDR_ISTAT ? {26'h0, intStatus} :
                         rdAddr == `CPFS_ADDR_IMASK ? {26'h0, intMask} : 32'h0000_0000;

    // configuration and interrupt registers
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg       <= `CPFS_CFG_RST;
            intStatus <= '0;
            intMask   <= `CPFS_IMASK_RST;
        end else begin
            if (wrCfg) cfg <= wrData[4:0];
            if (wrImask) intMask <= wrData[`CPFS_NEV-1:0];
            intStatus <= next_intStatus;
        end
    end

    // registered function outputs
    always_ff @(posedge clk) begin
        if (srst) funcQ <= '0;
        else funcQ <= next_func;
    end

    // outputs; pin c carries the interrupt for codes 1xxx
    assign inputLimitSel         = funcQ.lim;
    assign chargeEnable          = funcQ.chgEn;
    assign chargeCtrlOwned       = funcQ.chgOwn;
    assign rechargeDisable       = funcQ.rch;
    assign regulatorDisable      = funcQ.regOff;
    assign fastChargeHalve       = funcQ.half;
    assign chargerCircuitDisable = funcQ.cd;
    assign irq                   = |(intStatus & intMask);
    assign configPinCOe          = funcQ.irqPin; // RL4
    assign configPinCOut         = funcQ.irqPin & irq; // RL4

    cpfs_axil_port u_port (
        .clk     (clk),
        .srst    (srst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrOk    (wrOk),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .rdOk    (rdOk)
    );

    // helper state for the checks: code held steady since last cycle
    logic       live;
    logic [3:0] prevCode;
    always_ff @(posedge clk) begin
        if (srst) begin
            live     <= 1'b0;
            prevCode <= 4'h0;
        end else begin
            live     <= 1'b1;
            prevCode <= optCode;
        end
    end
    wire steady = live && optCode == prevCode;
    wire sA = pinSync[0];
    wire sB = pinSync[1];
    wire sC = pinSync[2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // code 0100: limit and regulator
    property p_code4;
        steady && optCode == `CPFS_OPT_4 |->
            inputLimitSel == ($past(sB) ? 2'h3 : ($past(aEff) ? 2'h2 : 2'h1)) && regulatorDisable == $past(sC);
    endproperty
    a_code4: assert property (p_code4) else $error("code 0100 decode wrong"); // RL1

    // code 0101: pin c gates charging
    property p_code5;
        steady && optCode == `CPFS_OPT_5 |->
            chargeCtrlOwned && chargeEnable == $past(sC) && inputLimitSel == ($past(sB) ? 2'h3 :
            ($past(aEff) ? 2'h2 : 2'h1));
    endproperty
    a_code5: assert property (p_code5) else $error("code 0101 decode wrong"); // RL2

    // codes 0110 and 0111
    property p_code67;
        steady && (optCode == `CPFS_OPT_6 || optCode == `CPFS_OPT_7) |->
            (optCode == `CPFS_OPT_6) ? (rechargeDisable == $past(sB) && chargeEnable == $past(sC)) :
            (chargeEnable == $past(aEff) && chargerCircuitDisable == $past(sB) && rechargeDisable == $past(sC));
    endproperty
    a_code67: assert property (p_code67) else $error("code 0110/0111 decode wrong"); // RL3

    // interrupt codes drive pin c from the interrupt level
    property p_irqpin;
        steady && optCode[`CPFS_IRQ_BIT] |-> configPinCOe && configPinCOut == irq &&
            (optCode != `CPFS_OPT_9 || (chargeEnable == $past(sB) && inputLimitSel == ($past(aEff) ? 2'h2 : 2'h1)));
    endproperty
    a_irqpin: assert property (p_irqpin) else $error("pin c interrupt drive wrong"); // RL4

    // pin b roles for codes 1010 to 1101
    property p_pinb;
        steady |-> (optCode != `CPFS_OPT_C || fastChargeHalve == $past(sB)) &&
            (optCode != `CPFS_OPT_A || chargerCircuitDisable == $past(sB)) &&
            (optCode != `CPFS_OPT_B || rechargeDisable == $past(sB)) &&
            (optCode != `CPFS_OPT_D || regulatorDisable == $past(sB));
    endproperty
    a_pinb: assert property (p_pinb) else $error("pin b role wrong"); // RL5

    // codes 1110 and 1111
    property p_code_ef;
        steady && (optCode == `CPFS_OPT_E || optCode == `CPFS_OPT_F) |-> chargeEnable == $past(sB) &&
            ((optCode == `CPFS_OPT_E) ? inputLimitSel == ($past(aEff) ? 2'h3 : 2'h0) :
            chargerCircuitDisable == $past(aEff));
    endproperty
    a_code_ef: assert property (p_code_ef) else $error("code 1110/1111 decode wrong"); // RL6

    // default code 0000
    property p_code0;
        steady && optCode == `CPFS_OPT_0 |-> chargerCircuitDisable == $past(sB) &&
            chargeEnable == $past(sC) && !configPinCOe;
    endproperty
    a_code0: assert property (p_code0) else $error("code 0000 decode wrong"); // RL7

    // polarity inverts the raw pin a level
    property p_polarity;
        steady && optCode == `CPFS_OPT_0 |->
            inputLimitSel == (($past(sA) != $past(polLow)) ? 2'h2 : 2'h1);
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin a polarity wrong"); // RL8

    // unlisted code has no effect
    property p_unlisted;
        steady && optCode == `CPFS_OPT_BAD |-> inputLimitSel == 2'h0 && !chargeCtrlOwned &&
            !rechargeDisable && !regulatorDisable && !fastChargeHalve && !chargerCircuitDisable && !configPinCOe;
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted code has effect"); // RL9

    // a function change is caught in status one cycle later
    property p_sticky;
        |evVec |=> (intStatus & $past(evVec)) == $past(evVec);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event not latched");

    c_limit1500: cover property (steady && optCode == `CPFS_OPT_4 && inputLimitSel == 2'h3);
    c_irqout:    cover property (configPinCOe && $rose(configPinCOut));
    c_halve:     cover property (optCode == `CPFS_OPT_C && $rose(fastChargeHalve));
    c_clear:     cover property ($fell(irq));
endmodule : cpfs_pin_select

// ===== tb/cpfs_host_gpio.sv
// host gpio model driving the three configurable pins
// assumes the bench resolves pin c from the device drive enable alone
`timescale 1ns/1ps
module cpfs_host_gpio (
    input  wire logic clk,    // system clock
    input  wire logic setA,   // wanted level on pin a
    input  wire logic setB,   // wanted level on pin b
    input  wire logic setC,   // wanted level on pin c
    input  wire logic devCOe, // device drives pin c
    output logic      pinA,   // host drive on pin a
    output logic      pinB,   // host drive on pin b
    output logic      hostC   // host level on pin c
);
    // gpio lines start low before the first edge
    initial {pinA, pinB, hostC} = 3'b000;
    // output register moves just after the edge; c toggles while the device drives it so stale levels never match
    always @(posedge clk) begin
        pinA  <= setA;
        pinB  <= setB;
        hostC <= devCOe ? ~hostC : setC;
    end
endmodule : cpfs_host_gpio

// ===== tb/charger_config_pin_function_select_bench.sv
// bench for the pin function selector: register access, decode sweep, interrupt
// assumes the host gpio model and the design sources are compiled first
`timescale 1ns/1ps
`include "cpfs_consts.svh"
module charger_config_pin_function_select_bench;
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp, lim;
    logic        setA, setB, setC, pinA, pinB, hostC, pinCOut, pinCOe, irq;
    logic        chgEn, chgOwn, rch, regDis, half, cd;
    logic [8:0]  want;
    int          failures, total_checks, cycles;
    wire         pinCWire = pinCOe ? pinCOut : hostC; // resolved level of pin c
    wire  [8:0]  seenFunc = {pinCOe, lim, chgEn, chgOwn, rch, regDis, half, cd};
    cpfs_pin_select i_dut (.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .configPinAIn(pinA), .configPinBIn(pinB), .configPinCIn(pinCWire),
        .configPinCOut(pinCOut), .configPinCOe(pinCOe), .inputLimitSel(lim), .chargeEnable(chgEn),
        .chargeCtrlOwned(chgOwn), .rechargeDisable(rch), .regulatorDisable(regDis), .fastChargeHalve(half),
        .chargerCircuitDisable(cd), .irq(irq));
    cpfs_host_gpio i_host (.clk(clk), .setA(setA), .setB(setB), .setC(setC), .devCOe(pinCOe), .pinA(pinA),
        .pinB(pinB), .hostC(hostC));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // cycle watchdog ends a hung run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            close_out();
        end
    end
    // expected {oe, limit, enable, owned, recharge, regulator, halve, disable}; a is polarity corrected
    function automatic logic [8:0] expf(input logic [3:0] k, input logic a, input logic b, input logic c);
        logic [1:0] la, lb;
        logic [8:0] f;
        la = a ? 2'h2 : 2'h1;
        lb = b ? 2'h3 : la;
        f = {k[3], 8'h00};
        case (k)
            4'h0: f[7:0] = {la, c, 1'b1, 3'b000, b};
            4'h2: f[7:0] = {lb, 5'h00, c};
            4'h3: f[7:0] = {lb, 4'h0, c, 1'b0};
            4'h4: f[7:0] = {lb, 3'b000, c, 2'b00};
            4'h5: f[7:0] = {lb, c, 1'b1, 4'h0};
            4'h6: f[7:0] = {la, c, 1'b1, b, 3'b000};
            4'h7: f[7:0] = {2'h0, a, 1'b1, c, 2'b00, b};
            4'h8: f[7:0] = {lb, 6'h00};
            4'h9: f[7:0] = {la, b, 1'b1, 4'h0};
            4'hA: f[7:0] = {la, 5'h00, b};
            4'hB: f[7:0] = {la, 2'b00, b, 3'b000};
            4'hC: f[7:0] = {la, 4'h0, b, 1'b0};
            4'hD: f[7:0] = {la, 3'b000, b, 2'b00};
            4'hE: f[7:0] = {a ? 2'h3 : 2'h0, b, 1'b1, 4'h0};
            4'hF: f[7:0] = {2'h0, b, 1'b1, 3'b000, a};
            default: f = 9'h000;
        endcase
        return f;
    endfunction : expf
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read
    task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        axi_write(a, d);
        check({30'h0, resp}, {30'h0, er});
    endtask : wr_chk
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        axi_read(a);
        check(rd, exp);
        check({30'h0, resp}, {30'h0, er});
    endtask : rd_chk
    task automatic set_pins(input logic a, input logic b, input logic c);
        @(posedge clk);
        setA <= a;
        setB <= b;
        setC <= c;
        repeat (6) @(posedge clk);
    endtask : set_pins
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, setA, setB, setC} = 8'h00;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hF;
        srst = 1'b1;
        {failures, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_chk(`CPFS_ADDR_CFG, 32'h0, `CPFS_RESP_OKAY);
        rd_chk(`CPFS_ADDR_IMASK, 32'h0, `CPFS_RESP_OKAY);
        rd_chk(`CPFS_ADDR_ISTAT, 32'h0, `CPFS_RESP_OKAY);
        rd_chk(`CPFS_ADDR_STATE, 32'h9, `CPFS_RESP_OKAY);
        wr_chk(`CPFS_ADDR_STATE, 32'hFFFF, `CPFS_RESP_OKAY);
        rd_chk(`CPFS_ADDR_STATE, 32'h9, `CPFS_RESP_OKAY);
        rd_chk(4'h2, 32'h0, `CPFS_RESP_SLV);
        // a write without the low byte strobe must leave the config untouched
        wstrb <= 4'hE;
        wr_chk(`CPFS_ADDR_CFG, 32'h1F, `CPFS_RESP_OKAY);
        wstrb <= 4'hF;
        rd_chk(`CPFS_ADDR_CFG, 32'h0, `CPFS_RESP_OKAY);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 16; k++) begin
                wr_chk(`CPFS_ADDR_CFG, {27'h0, p[0], k[3:0]}, `CPFS_RESP_OKAY);
                for (int v = 0; v < 8; v++) begin
                    set_pins(v[0], v[1], v[2]);
                    want = expf(k[3:0], v[0] ^ p[0], v[1], v[2]);
                    check({23'h0, seenFunc}, {23'h0, want});
                end
            end
        end
        $display("test decode sweep done");
        wr_chk(`CPFS_ADDR_CFG, 32'h8, `CPFS_RESP_OKAY);
        set_pins(1'b0, 1'b0, 1'b0);
        wr_chk(`CPFS_ADDR_ISTAT, 32'h3F, `CPFS_RESP_OKAY);
        rd_chk(`CPFS_ADDR_ISTAT, 32'h0, `CPFS_RESP_OKAY);
        set_pins(1'b0, 1'b1, 1'b0);
        rd_chk(`CPFS_ADDR_ISTAT, 32'h20, `CPFS_RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        wr_chk(`CPFS_ADDR_IMASK, 32'h20, `CPFS_RESP_OKAY);
        check({30'h0, irq, pinCWire}, 32'h3);
        wr_chk(`CPFS_ADDR_ISTAT, 32'h20, `CPFS_RESP_OKAY);
        check({30'h0, irq, pinCWire}, 32'h0);
        rd_chk(`CPFS_ADDR_ISTAT, 32'h0, `CPFS_RESP_OKAY);
        $display("test interrupt done");
        close_out();
    end
endmodule : charger_config_pin_function_select_bench
